// [bench/cpu_bus_model.sv]
`timescale 1ns/1ps
module cpu_bus_model
  import dbg_trace_pkg::*;
(
  input  wire logic clk_i,
  output cpu_bus_t  bus_o,
  output cof_t      cof_o
);
  // ==========================================
  // One bus cycle followed by one idle cycle
  initial begin
    bus_o = '0;
    cof_o = '0;
  end
  // Idle cycles invert address and data so a stale value can never pass for a match.
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic [1:0] fl, input cof_t c);
    @(posedge clk_i);
    bus_o <= '{1'b1, 1'b1, fl[0], fl[1], a, d, ~d, fl[0], a};
    cof_o <= c;
    @(posedge clk_i);
    bus_o <= '{1'b0, 1'b0, 1'b0, 1'b0, ~a, ~d, d, 1'b0, ~a};
    cof_o <= '0;
  endtask
endmodule

// [bench/onchip_bus_trace_trigger_asserts.sv]
`timescale 1ns/1ps
`include "dbg_trace_cfg.svh"
module onchip_bus_trace_trigger_asserts
  import dbg_trace_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic       CLK_SYS_I,
  input wire logic       RST_B_I,
  input wire cpu_bus_t   CPU_BUS_I,
  input wire logic       CPU_BRK_REQ_O,
  input wire logic       S_AXI_AWVALID_I,
  input wire logic       S_AXI_AWREADY_O,
  input wire logic       S_AXI_WVALID_I,
  input wire logic       S_AXI_WREADY_O,
  input wire logic       S_AXI_BVALID_O,
  input wire logic       S_AXI_ARVALID_I,
  input wire logic       S_AXI_ARREADY_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic       S_AXI_RVALID_O,
  input wire logic [1:0] S_AXI_RRESP_O
);
  // ==========================================
  // Break timing and register bus handshakes
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_B_I);
  sequence s_wr; S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O; endsequence
  sequence s_rd; S_AXI_ARVALID_I && S_AXI_ARREADY_O; endsequence
  property p_brk_src; CPU_BRK_REQ_O |-> $past(CPU_BUS_I.valid) || $past(CPU_BUS_I.exec); endproperty
  a_brk_src: assert property (p_brk_src) else $error("break without bus cycle");
  property p_bdc; CPU_BUS_I.valid && CPU_BUS_I.bdc_access && !CPU_BUS_I.exec |=> !CPU_BRK_REQ_O; endproperty
  a_bdc: assert property (p_bdc) else $error("break on link access");
  property p_wr_busy; s_wr |=> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write not held off");
  property p_b_ans; s_wr |-> ##[1:2] S_AXI_BVALID_O; endproperty
  a_b_ans: assert property (p_b_ans) else $error("no write response");
  property p_b_busy; S_AXI_BVALID_O |-> !S_AXI_AWREADY_O; endproperty
  a_b_busy: assert property (p_b_busy) else $error("address taken during response");
  property p_r_ans; s_rd |=> S_AXI_RVALID_O; endproperty
  a_r_ans: assert property (p_r_ans) else $error("no read response");
  property p_ar_hold; S_AXI_RVALID_O |-> !S_AXI_ARREADY_O; endproperty
  a_ar_hold: assert property (p_ar_hold) else $error("read taken during response");
  property p_unmap; s_rd ##0 S_AXI_ARADDR_I > `OFS_FIFO_LOW |=> S_AXI_RRESP_O == `RESP_SLVERR; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
endmodule

bind onchip_bus_trace_trigger onchip_bus_trace_trigger_asserts #(.DEPTH(DEPTH)) chk_u (.CLK_SYS_I, .RST_B_I,
  .CPU_BUS_I, .CPU_BRK_REQ_O, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O,
  .S_AXI_BVALID_O, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_ARADDR_I, .S_AXI_RVALID_O, .S_AXI_RRESP_O);

// [bench/tb_onchip_bus_trace_trigger.sv]
`timescale 1ns/1ps
`include "dbg_trace_cfg.svh"
module tb_onchip_bus_trace_trigger
  import dbg_trace_pkg::*;
;
  logic        clk, rst_b, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, brk, tg;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, v;
  logic [3:0]  wst;
  logic [1:0]  br, rr, r;
  logic [15:0] h, q[$];
  logic [15:0] ra[4] = '{16'h0fff, 16'h1000, 16'h2000, 16'h2001};
  cof_t        cl[8] = '{'{COF_INT_RETURN, 16'h1, 16'h1111}, '{COF_INDIRECT, 16'h2, 16'h2222},
                 '{COF_INDIRECT, 16'h3, 16'h3333}, '{COF_COND_TAKEN, 16'h4444, 16'h5555},
                 '{COF_BRANCH_ALWAYS, 16'h6, 16'h6666}, '{COF_BRANCH_NEVER, 16'h7, 16'h6667},
                 '{COF_INDIRECT, 16'h8, 16'h7777}, '{COF_INT_RETURN, 16'h9, 16'h8888}};
  cpu_bus_t    bus;
  cof_t        cof;
  int          num_errors, n_tests, brks, cyc_n, n;

  onchip_bus_trace_trigger #(.DEPTH(8)) dut_u (.CLK_SYS_I(clk), .RST_B_I(rst_b), .CPU_BUS_I(bus),
    .CPU_COF_I(cof), .CPU_BRK_REQ_O(brk), .CPU_BRK_TAG_O(tg), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(wst),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry), .S_AXI_BRESP_O(br), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr));
  cpu_bus_model cpu (.clk_i(clk), .bus_o(bus), .cof_o(cof));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (rst_b && brk === 1'b1) brks++;
    if (cyc_n == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awv, wv, bry} <= 3'b111;
    awa <= a;
    wd <= d;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
    r = br;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {arv, rry} <= 2'b11;
    ara <= a;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rry <= 1'b0;
    v = rdat;
    r = rr;
  endtask
  task automatic rdw();
    rd(`OFS_FIFO_HIGH);
    h = v[15:0];
    rd(`OFS_FIFO_LOW);
    v = {16'h0, h[7:0], v[7:0]};
  endtask
  function automatic logic hit(input int m, input logic [15:0] x);
    if (m == 5) return x == 16'h1000;
    if (m == 6) return 1'b0;
    return (m == 7) ? (x >= 16'h1000 && x <= 16'h2000) : (x < 16'h1000 || x > 16'h2000);
  endfunction
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    {awv, wv, bry, arv, rry, rst_b, awa, ara, wd} = '0;
    wst = 4'hf;
    v = $urandom(32'h6b3a);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h1c);
    chk("rresp", r, `RESP_SLVERR);
    wr(`OFS_DEBUG_STATUS, 32'hff);
    chk("bresp", r, `RESP_SLVERR);
    h = 16'($urandom);
    wr(`OFS_COMP_A, h);
    rd(`OFS_COMP_A);
    chk("comp_a", v, h);
    wr(`OFS_TRIG_CTRL, 0);
    wr(`OFS_DEBUG_CTRL, 32'h0b);
    rd(`OFS_DEBUG_STATUS);
    chk("armed", v, 32'h04);
    chk("tag_off", tg, 0);
    cpu.cyc(h, 8'h00, 2'b10, '0);
    cpu.cyc(h, 8'h00, 2'b00, '0);
    rd(`OFS_DEBUG_STATUS);
    chk("brk", brks, 1);
    chk("flag_a", v[0], 1);
    wr(`OFS_DEBUG_CTRL, 32'h0f);
    rd(`OFS_DEBUG_STATUS);
    chk("rearm", v[2:0], 3'b100);
    chk("tag_on", tg, 1);
    wr(`OFS_COMP_A, 32'h1000);
    wr(`OFS_COMP_B, 32'h2000);
    for (int m = 5; m < 9; m++)
      foreach (ra[i]) begin
        wr(`OFS_TRIG_CTRL, m);
        wr(`OFS_DEBUG_CTRL, 32'h0b);
        n = brks;
        cpu.cyc(ra[i], 8'h00, 2'b00, '0);
        rd(`OFS_DEBUG_STATUS);
        chk("range", brks - n, hit(m, ra[i]));
      end
    wr(`OFS_COMP_B, 32'h3000);
    wr(`OFS_TRIG_CTRL, 3);
    wr(`OFS_DEBUG_CTRL, 32'h03);
    repeat (9) begin
      h = 16'($urandom);
      q.push_back(h[7:0]);
      cpu.cyc(16'h3000, h[7:0], 2'b00, '0);
    end
    rd(`OFS_DEBUG_STATUS);
    chk("count", {v[7:4], v[2]}, 5'b10000);
    for (int i = 0; i < 8; i++) begin
      rd(`OFS_FIFO_LOW);
      chk("event", v[7:0], q[i]);
    end
    wr(`OFS_COMP_A, 32'h4000);
    wr(`OFS_TRIG_CTRL, 32'h40);
    wr(`OFS_DEBUG_CTRL, 32'h03);
    foreach (cl[i]) cpu.cyc(i ? 16'h0100 + 16'(i) : 16'h4000, 8'h00, 2'b00, cl[i]);
    rd(`OFS_DEBUG_STATUS);
    chk("cof_count", v[7:4], 3);
    wr(`OFS_DEBUG_CTRL, 32'h01);
    repeat (4) rd(`OFS_FIFO_LOW);
    q = '{16'h4444, 16'h7777, 16'h8888};
    foreach (q[i]) begin
      rdw();
      chk("cof", v[15:0], q[i]);
    end
    cpu.cyc(16'h5a5a, 8'h00, 2'b01, '0);
    repeat (8) rd(`OFS_FIFO_LOW);
    rdw();
    chk("profile", v[15:0], 16'h5a5a);
    end_sim();
  end
endmodule

// [src/dbg_trace_cfg.svh]
`ifndef DBG_TRACE_CFG_SVH
`define DBG_TRACE_CFG_SVH

// ==========================================================================
// Register byte offsets
`define OFS_COMP_A        8'h00
`define OFS_COMP_B        8'h04
`define OFS_DEBUG_CTRL    8'h08
`define OFS_TRIG_CTRL     8'h0c
`define OFS_DEBUG_STATUS  8'h10
`define OFS_FIFO_HIGH     8'h14
`define OFS_FIFO_LOW      8'h18

// ==========================================================================
// Field positions of debug_control_reg
`define CTRL_DBG_EN       0
`define CTRL_ARM          1
`define CTRL_TAG          2
`define CTRL_BRK_EN       3
`define CTRL_RWA          4
`define CTRL_RW_QUALIFY_ENABLE_A        5
`define CTRL_RWB          6
`define CTRL_RWBEN        7

// ==========================================================================
// Field positions of trigger_control_reg and debug_status_reg
`define TRIG_MODE_LSB     0
`define TRIG_BEGIN        6
`define TRIG_TRGSEL       7
`define STAT_AF           0
`define STAT_BF           1
`define STAT_ARMED_FLAG         2
`define STAT_CNT_LSB      4

// ==========================================================================
// Reset values, depths and timing
`define RST_COMP          16'h0000
`define RST_CTRL          8'h00
`define RST_TRIG          8'h00
`define FIFO_DEPTH        8
`define COF_HOLDOFF       2'h2
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [src/dbg_trace_pkg.sv]
package dbg_trace_pkg;

  // ========================================================================
  // Trigger modes, run states and change-of-flow kinds
  typedef enum logic [3:0] {
    TRG_A_ONLY      = 4'h0,
    TRG_A_OR_B      = 4'h1,
    TRG_A_THEN_B    = 4'h2,
    TRG_EVENT_B     = 4'h3,
    TRG_A_THEN_EV_B = 4'h4,
    TRG_A_AND_B     = 4'h5,
    TRG_A_AND_NOT_B = 4'h6,
    TRG_INSIDE      = 4'h7,
    TRG_OUTSIDE     = 4'h8
  } trigger_mode_select_t;

  typedef enum logic [1:0] {
    RUN_IDLE    = 2'b00,
    RUN_WAIT    = 2'b01,
    RUN_CAPTURE = 2'b11
  } run_state_t;

  typedef enum logic [2:0] {
    COF_NONE         = 3'h0,
    COF_COND_TAKEN   = 3'h1,
    COF_BRANCH_ALWAYS = 3'h2,
    COF_BRANCH_NEVER = 3'h3,
    COF_INDIRECT     = 3'h4,
    COF_INT_RETURN   = 3'h5
  } cof_kind_t;

  // ========================================================================
  // CPU side carriers
  typedef struct packed {
    logic        valid;
    logic        rw;
    logic        opfetch;
    logic        bdc_access;
    logic [15:0] addr;
    logic [7:0]  rdata;
    logic [7:0]  wdata;
    logic        exec;
    logic [15:0] exec_addr;
  } cpu_bus_t;

  typedef struct packed {
    cof_kind_t   kind;
    logic [15:0] src_addr;
    logic [15:0] dst_addr;
  } cof_t;

endpackage

// [src/onchip_bus_trace_trigger.sv]
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dbg_trace_cfg.svh"
module onchip_bus_trace_trigger
  import dbg_trace_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_B_I,
  input  wire cpu_bus_t    CPU_BUS_I,
  input  wire cof_t        CPU_COF_I,
  output logic             CPU_BRK_REQ_O,
  output logic             CPU_BRK_TAG_O,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  output logic [1:0]       S_AXI_BRESP_O,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O
);

  // ========================================================================
  // Registers and internal state
  logic [15:0]          comp_a_q;
  logic [15:0]          comp_b_q;
  logic [7:0]           debug_control_reg_q;
  logic [7:0]           trigger_control_reg_q;
  logic                 comp_a_match_flag_q;
  logic                 comp_b_match_flag_q;
  logic [3:0]           valid_word_count_q;
  run_state_t           run_q;
  logic                 a_seen_q;
  logic [1:0]           holdoff_q;
  logic                 pend_a_q;
  logic                 pend_b_q;
  logic [15:0]          pend_a_addr_q;
  logic [15:0]          pend_b_addr_q;
  logic [15:0]          last_fetch_q;
  logic [15:0]          fifo_q [DEPTH];
  logic [7:0]           awaddr_q;
  logic                 have_aw_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 have_w_q;

  trigger_mode_select_t mode;
  logic                 dbg_en, tag, brk_en, rw_match_value_a, rw_qualify_enable_a, rwb, rwben, trgsel, begin_type;
  logic                 event_mode, full_mode, live;
  logic                 rw_ok_a, rw_ok_b, raw_a, raw_b, data_eq, qa, qb;
  logic                 in_range, trig, tag_trig;
  logic [7:0]           data_sel;
  logic                 cof_store_ok;
  logic [15:0]          cof_addr;
  logic                 store_en;
  logic [15:0]          store_val;
  logic                 wr_fire, rd_fire, rd_low, arm_write, stop_write, manual_halt;
  logic [7:0]           ctrl_new;

  assign mode       = trigger_mode_select_t'(trigger_control_reg_q[`TRIG_MODE_LSB +: 4]);
  assign dbg_en     = debug_control_reg_q[`CTRL_DBG_EN];
  assign tag        = debug_control_reg_q[`CTRL_TAG];
  assign brk_en     = debug_control_reg_q[`CTRL_BRK_EN];
  assign rw_match_value_a        = debug_control_reg_q[`CTRL_RWA];
  assign rw_qualify_enable_a      = debug_control_reg_q[`CTRL_RW_QUALIFY_ENABLE_A];
  assign rwb        = debug_control_reg_q[`CTRL_RWB];
  assign rwben      = debug_control_reg_q[`CTRL_RWBEN];
  assign trgsel     = trigger_control_reg_q[`TRIG_TRGSEL];
  assign event_mode = (mode == TRG_EVENT_B) || (mode == TRG_A_THEN_EV_B);
  assign full_mode  = (mode == TRG_A_AND_B) || (mode == TRG_A_AND_NOT_B);
  // Event-only runs ignore the begin bit and always behave as begin traces.
  assign begin_type = trigger_control_reg_q[`TRIG_BEGIN] || event_mode;

  // ========================================================================
  // Comparators
  // Accesses made on behalf of the background link never match.
  assign live     = CPU_BUS_I.valid && !CPU_BUS_I.bdc_access && dbg_en;
  assign rw_ok_a  = !rw_qualify_enable_a || (CPU_BUS_I.rw == rw_match_value_a);
  assign rw_ok_b  = !rwben || (CPU_BUS_I.rw == rwb);
  assign raw_a    = live && rw_ok_a && (CPU_BUS_I.addr == comp_a_q);
  assign raw_b    = live && rw_ok_b && (CPU_BUS_I.addr == comp_b_q);
  assign data_sel = (rw_qualify_enable_a && !rw_match_value_a) ? CPU_BUS_I.wdata : CPU_BUS_I.rdata;
  assign data_eq  = (data_sel == comp_b_q[7:0]);
  assign in_range = (CPU_BUS_I.addr >= comp_a_q) && (CPU_BUS_I.addr <= comp_b_q);

  // Each comparator has its own tracker, so two fetched tags can be in flight at once.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pend_a_q      <= 1'b0;
      pend_b_q      <= 1'b0;
      pend_a_addr_q <= `RST_COMP;
      pend_b_addr_q <= `RST_COMP;
    end else begin
      if (raw_a && CPU_BUS_I.opfetch) begin
        pend_a_q      <= 1'b1;
        pend_a_addr_q <= CPU_BUS_I.addr;
      end else if (CPU_BUS_I.exec && pend_a_q && CPU_BUS_I.exec_addr == pend_a_addr_q) begin
        pend_a_q <= 1'b0;
      end
      if (raw_b && CPU_BUS_I.opfetch) begin
        pend_b_q      <= 1'b1;
        pend_b_addr_q <= CPU_BUS_I.addr;
      end else if (CPU_BUS_I.exec && pend_b_q && CPU_BUS_I.exec_addr == pend_b_addr_q) begin
        pend_b_q <= 1'b0;
      end
    end
  end

  // With tracking on, a match counts only when the tagged opcode reaches execution.
  always_comb begin
    if (trgsel) begin
      qa = dbg_en && CPU_BUS_I.exec && pend_a_q && (CPU_BUS_I.exec_addr == pend_a_addr_q);
      qb = dbg_en && CPU_BUS_I.exec && pend_b_q && (CPU_BUS_I.exec_addr == pend_b_addr_q);
    end else begin
      qa = raw_a;
      qb = raw_b;
    end
  end

  // ========================================================================
  // Trigger decode
  always_comb begin
    tag_trig = qa;
    case (mode)
      TRG_A_ONLY:      trig = qa;
      TRG_A_OR_B:      trig = qa || qb;
      TRG_A_THEN_B:    trig = qb && a_seen_q;
      TRG_EVENT_B:     trig = qb;
      TRG_A_THEN_EV_B: trig = qb && a_seen_q;
      TRG_A_AND_B:     trig = qa && data_eq;
      TRG_A_AND_NOT_B: trig = qa && !data_eq;
      TRG_INSIDE:      trig = live && rw_ok_a && in_range;
      TRG_OUTSIDE:     trig = live && rw_ok_a && !in_range;
      default:         trig = 1'b0;
    endcase
    // A tag request in full modes ignores the data half and fires on the address.
    if (!full_mode) begin
      tag_trig = trig;
    end
  end

  // ========================================================================
  // Change-of-flow address selection
  always_comb begin
    cof_addr = CPU_COF_I.dst_addr;
    cof_store_ok = 1'b1;
    case (CPU_COF_I.kind)
      COF_COND_TAKEN:    cof_addr = CPU_COF_I.src_addr;
      COF_INDIRECT:      cof_addr = CPU_COF_I.dst_addr;
      COF_INT_RETURN:    cof_addr = CPU_COF_I.dst_addr;
      COF_BRANCH_ALWAYS: cof_store_ok = 1'b0;
      COF_BRANCH_NEVER:  cof_store_ok = 1'b0;
      default:           cof_store_ok = 1'b0;
    endcase
  end

  // ========================================================================
  // Run control and store decision
  always_comb begin
    store_en  = 1'b0;
    store_val = {8'h00, data_sel};
    if (run_q == RUN_CAPTURE) begin
      if (event_mode) begin
        store_en  = trig;
        store_val = {8'h00, CPU_BUS_I.rw ? CPU_BUS_I.rdata : CPU_BUS_I.wdata};
      end else if (begin_type) begin
        store_en  = cof_store_ok && (holdoff_q == 2'h0);
        store_val = cof_addr;
      end else begin
        // The triggering change-of-flow of an end trace is kept as its last entry.
        store_en  = cof_store_ok;
        store_val = cof_addr;
      end
    end else if (run_q == RUN_IDLE && rd_low) begin
      store_en  = 1'b1;
      store_val = last_fetch_q;
    end
  end

  assign ctrl_new    = S_AXI_WSTRB_I[0] ? S_AXI_WDATA_I[7:0] : debug_control_reg_q;
  assign wr_fire     = have_aw_q && have_w_q && !S_AXI_BVALID_O;
  assign rd_fire     = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign rd_low      = rd_fire && (S_AXI_ARADDR_I == `OFS_FIFO_LOW);
  assign arm_write   = wr_fire && (awaddr_q == `OFS_DEBUG_CTRL) && wstrb_q[0] &&
                       wdata_q[`CTRL_ARM] && wdata_q[`CTRL_DBG_EN];
  assign stop_write  = wr_fire && (awaddr_q == `OFS_DEBUG_CTRL) && wstrb_q[0] &&
                       (!wdata_q[`CTRL_ARM] || !wdata_q[`CTRL_DBG_EN]);
  assign manual_halt = stop_write && (run_q != RUN_IDLE) && (valid_word_count_q != 4'(DEPTH));

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      run_q     <= RUN_IDLE;
      a_seen_q  <= 1'b0;
      holdoff_q <= 2'h0;
    end else if (arm_write) begin
      run_q     <= (begin_type && !event_mode) ? RUN_WAIT : RUN_CAPTURE;
      a_seen_q  <= 1'b0;
      holdoff_q <= 2'h0;
    end else if (stop_write) begin
      run_q <= RUN_IDLE;
    end else begin
      if (qa && run_q != RUN_IDLE) begin
        a_seen_q <= 1'b1;
      end
      if (holdoff_q != 2'h0 && CPU_BUS_I.valid) begin
        holdoff_q <= holdoff_q - 2'h1;
      end
      case (run_q)
        RUN_WAIT: begin
          if (trig) begin
            run_q     <= RUN_CAPTURE;
            holdoff_q <= `COF_HOLDOFF;
          end
        end
        RUN_CAPTURE: begin
          if (!begin_type && trig) begin
            run_q <= RUN_IDLE;
          end else if (begin_type && store_en && valid_word_count_q == 4'(DEPTH - 1)) begin
            run_q <= RUN_IDLE;
          end
        end
        default: run_q <= RUN_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Match flags, count and profiling source
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      comp_a_match_flag_q <= 1'b0;
      comp_b_match_flag_q <= 1'b0;
      valid_word_count_q  <= 4'h0;
    end else begin
      if (arm_write) begin
        comp_a_match_flag_q <= 1'b0;
        comp_b_match_flag_q <= 1'b0;
        valid_word_count_q  <= 4'h0;
      end
      // A match in the arming cycle still lands if the run was already active, so the set wins over the clear.
      if (qa && run_q != RUN_IDLE) begin
        comp_a_match_flag_q <= 1'b1;
      end
      if (qb && run_q != RUN_IDLE) begin
        comp_b_match_flag_q <= 1'b1;
      end
      if (store_en && run_q != RUN_IDLE && valid_word_count_q != 4'(DEPTH)) begin
        valid_word_count_q <= valid_word_count_q + 4'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      last_fetch_q <= `RST_COMP;
    end else if (CPU_BUS_I.valid && CPU_BUS_I.opfetch && !CPU_BUS_I.bdc_access) begin
      last_fetch_q <= CPU_BUS_I.addr;
    end
  end

  // ========================================================================
  // Capture FIFO
  // Entries enter at the top and drain toward entry zero, which is the read port.
  // A read and a store in the same cycle shift once, so neither the read nor the store is lost.
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_fifo
      always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          fifo_q[gi] <= 16'h0000;
        end else if (store_en || rd_low || manual_halt) begin
          if (gi == DEPTH - 1) begin
            fifo_q[gi] <= store_en ? store_val : 16'h0000;
          end else begin
            fifo_q[gi] <= fifo_q[(gi + 1) % DEPTH];
          end
        end
      end
    end
  endgenerate

  // ========================================================================
  // Breakpoint request to the CPU
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CPU_BRK_REQ_O <= 1'b0;
      CPU_BRK_TAG_O <= 1'b0;
    end else begin
      CPU_BRK_REQ_O <= brk_en && (run_q != RUN_IDLE) && (tag ? tag_trig : trig);
      CPU_BRK_TAG_O <= tag;
    end
  end

  // ========================================================================
  // AXI4-Lite write channel
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O  <= 1'b1;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= `RESP_OKAY;
      have_aw_q       <= 1'b0;
      have_w_q        <= 1'b0;
      awaddr_q        <= 8'h00;
      wdata_q         <= 32'h0000_0000;
      wstrb_q         <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        awaddr_q        <= S_AXI_AWADDR_I;
        have_aw_q       <= 1'b1;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        wdata_q        <= S_AXI_WDATA_I;
        wstrb_q        <= S_AXI_WSTRB_I;
        have_w_q       <= 1'b1;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (wr_fire) begin
        have_aw_q      <= 1'b0;
        have_w_q       <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        case (awaddr_q)
          `OFS_COMP_A, `OFS_COMP_B, `OFS_DEBUG_CTRL, `OFS_TRIG_CTRL: S_AXI_BRESP_O <= `RESP_OKAY;
          default: S_AXI_BRESP_O <= `RESP_SLVERR;
        endcase
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O  <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O  <= 1'b1;
      end
    end
  end

  // Software-writable registers; these steer the comparators and run control.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      comp_a_q              <= `RST_COMP;
      comp_b_q              <= `RST_COMP;
      debug_control_reg_q   <= `RST_CTRL;
      trigger_control_reg_q <= `RST_TRIG;
    end else if (wr_fire) begin
      case (awaddr_q)
        `OFS_COMP_A: begin
          if (wstrb_q[0]) comp_a_q[7:0]  <= wdata_q[7:0];
          if (wstrb_q[1]) comp_a_q[15:8] <= wdata_q[15:8];
        end
        `OFS_COMP_B: begin
          if (wstrb_q[0]) comp_b_q[7:0]  <= wdata_q[7:0];
          if (wstrb_q[1]) comp_b_q[15:8] <= wdata_q[15:8];
        end
        `OFS_DEBUG_CTRL: begin
          if (wstrb_q[0]) debug_control_reg_q <= wdata_q[7:0];
        end
        `OFS_TRIG_CTRL: begin
          if (wstrb_q[0]) trigger_control_reg_q <= wdata_q[7:0];
        end
        default: ;
      endcase
    end
  end

  // ========================================================================
  // AXI4-Lite read channel
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= `RESP_OKAY;
    end else begin
      if (rd_fire) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O  <= 1'b1;
        S_AXI_RRESP_O   <= `RESP_OKAY;
        S_AXI_RDATA_O   <= 32'h0000_0000;
        case (S_AXI_ARADDR_I)
          `OFS_COMP_A:       S_AXI_RDATA_O[15:0] <= comp_a_q;
          `OFS_COMP_B:       S_AXI_RDATA_O[15:0] <= comp_b_q;
          `OFS_DEBUG_CTRL:   S_AXI_RDATA_O[7:0]  <= {debug_control_reg_q[7:2],
                                                     run_q != RUN_IDLE, debug_control_reg_q[0]};
          `OFS_TRIG_CTRL:    S_AXI_RDATA_O[7:0]  <= trigger_control_reg_q;
          `OFS_DEBUG_STATUS: S_AXI_RDATA_O[7:0]  <= {valid_word_count_q, 1'b0, run_q != RUN_IDLE,
                                                     comp_b_match_flag_q, comp_a_match_flag_q};
          `OFS_FIFO_HIGH:    S_AXI_RDATA_O[7:0]  <= fifo_q[0][15:8];
          `OFS_FIFO_LOW:     S_AXI_RDATA_O[7:0]  <= fifo_q[0][7:0];
          default:           S_AXI_RRESP_O       <= `RESP_SLVERR;
        endcase
      end
      if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O  <= 1'b0;
        S_AXI_ARREADY_O <= 1'b1;
      end
    end
  end

endmodule
